/* rpmc_map.vh */
// constants for the reset and power mode controller
`ifndef RPMC_MAP_VH
`define RPMC_MAP_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define RPMC_CTRL_OFS 12'h000
`define RPMC_STAT_OFS 12'h004
`define RPMC_EXT_OFS 12'h008
`define RPMC_P2_OFS 12'h00c
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define RPMC_CTRL_IDLE 0
`define RPMC_CTRL_PDOWN 1
`define RPMC_CTRL_CA_RUN 2
`define RPMC_CTRL_LOCK 3
`define RPMC_CTRL_IRQ0_EN 4
`define RPMC_CTRL_IRQ1_EN 5
`define RPMC_CTRL_IRQ0_LVL 6
`define RPMC_CTRL_IRQ1_LVL 7
`define RPMC_CTRL_RST 8'h00
// ------------------------------------------------------------
// external access request fields
// ------------------------------------------------------------
`define RPMC_EXT_DATA 0
`define RPMC_EXT_IND8 1
`define RPMC_EXT_WR 2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RPMC_OSC_PER_MC 4'hc
`define RPMC_ALE_DIV 4'h6
`define RPMC_RST_MC 5'h02
`define RPMC_RST_OSC (`RPMC_RST_MC * `RPMC_OSC_PER_MC)
`define RPMC_IDLE_GRACE_MC 2'h2
`endif

/* rpmc_top.v */
// reset, idle, power-down and emulation mode controller
`timescale 1ns/1ps
// ------------------------------------------------------------
// Overview of operation
// - reset taken after reset pin high two machine cycles, oscillator running
// - address latch strobe pulses at one sixth oscillator rate normally
// - one latch strobe pulse dropped per external data access
// - fetch strobe pulses twice per machine cycle when code is external
// - two fetch strobe pulses dropped per external data access
// - select input low means all code fetched externally
// - with lock set, code select captured at reset and held
// - indirect 8-bit data access drives port two latch on high port
// - port three carries serial, irq, timer inputs, write and read strobes
// - internal clocking via divide-by-two of oscillator input
// - idle stops execution, registers and ram kept
// - idle left on reset or any enabled interrupt
// - option chooses counter array running or frozen in idle
// - power-down stops oscillator after the requesting instruction
// - power-down left by reset or external irq; reset clears registers
// - level irq low restarts oscillator, return high completes exit
// - after wake handler, execution resumes after power-down instruction
// - reset ending idle allows two cycles; ram writes blocked, ports not
// - emulation floats port zero, pulls strobes high, oscillator runs
// - idle strobes high, power-down low; port drive per mode table
// ------------------------------------------------------------
`include "rpmc_map.vh"
module rpmc_top (
    input wire core_clk,
    input wire rst,
    input wire haddr_sel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire reset_pin,
    input wire ext_code_select,
    input wire ext_irq_zero,
    input wire ext_irq_one,
    input wire ale_pin_in,
    output reg ale_out,
    output reg ale_oe,
    output reg code_fetch_strobe,
    output reg code_fetch_oe,
    output reg port0_oe,
    output reg port2_addr_sel,
    output reg [7:0] port2_out,
    output reg data_wr_strobe,
    output reg data_rd_strobe,
    output reg osc_run,
    output reg cpu_run,
    output reg ram_wr_block,
    output reg sfr_reset,
    output reg counter_array_en,
    output reg resume_after_pd
);
// ------------------------------------------------------------
// modes
// ------------------------------------------------------------
localparam [4:0] ST_RESET = 5'h01;
localparam [4:0] ST_RUN = 5'h02;
localparam [4:0] ST_IDLE = 5'h04;
localparam [4:0] ST_PDOWN = 5'h08;
localparam [4:0] ST_EMUL = 5'h10;
localparam [3:0] OSC_MC = `RPMC_OSC_PER_MC;
localparam [4:0] RST_OSC = `RPMC_RST_OSC;

function [3:0] wrap_inc;
    input [3:0] v;
    input [3:0] lim;
    begin
        wrap_inc = (v == lim - 4'h1) ? 4'h0 : v + 4'h1;
    end
endfunction

// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
reg [1:0] rst_s;
reg [1:0] ea_s;
reg [1:0] i0_s;
reg [1:0] i1_s;
reg [1:0] ale_s;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        rst_s <= 2'h0;
        ea_s <= 2'h0;
        i0_s <= 2'h3;
        i1_s <= 2'h3;
        ale_s <= 2'h3;
    end else begin
        rst_s <= {rst_s[0], reset_pin};
        ea_s <= {ea_s[0], ext_code_select};
        i0_s <= {i0_s[0], ext_irq_zero};
        i1_s <= {i1_s[0], ext_irq_one};
        ale_s <= {ale_s[0], ale_pin_in};
    end
end
wire rst_in = rst_s[1];
wire i0_low = ~i0_s[1];
wire i1_low = ~i1_s[1];

// ------------------------------------------------------------
// bus slave
// ------------------------------------------------------------
reg [7:0] ctrl_reg;
reg [7:0] p2_reg;
reg [2:0] ext_reg;
reg ext_go_reg;
reg wr_pend_reg;
reg [11:0] wa_reg;
reg [4:0] state_reg;
reg [4:0] state_next;
reg ea_hold_reg;
reg ea_lat_reg;
wire take = haddr_sel & hready & htrans[1];
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        wr_pend_reg <= 1'b0;
        wa_reg <= 12'h000;
        hrdata <= 32'h0;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        wr_pend_reg <= take & hwrite;
        if (take) begin
            wa_reg <= haddr[11:0];
        end
        if (take & ~hwrite) begin
            case (haddr[11:0])
                `RPMC_CTRL_OFS: hrdata <= {24'h0, ctrl_reg};
                `RPMC_STAT_OFS: hrdata <= {26'h0, ea_hold_reg, state_reg};
                `RPMC_EXT_OFS: hrdata <= {28'h0, ext_go_reg, ext_reg};
                `RPMC_P2_OFS: hrdata <= {24'h0, p2_reg};
                default: hrdata <= 32'h0;
            endcase
        end
    end
end

// ------------------------------------------------------------
// reset qualification and oscillator timing
// ------------------------------------------------------------
reg [4:0] rcnt_reg;
reg rst_q_reg;
reg div2_reg;
reg [3:0] mc_reg;
reg [3:0] ale_ph_reg;
reg [1:0] skip_ale_reg;
reg [1:0] skip_ps_reg;
reg [1:0] idle_grace_reg;
wire osc_tick = osc_run & div2_reg;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        div2_reg <= 1'b0;
        mc_reg <= 4'h0;
        ale_ph_reg <= 4'h0;
        rcnt_reg <= 5'h0;
        rst_q_reg <= 1'b1;
    end else begin
        if (osc_run | (state_reg == ST_PDOWN)) begin
            div2_reg <= ~div2_reg;
        end
        if (osc_tick) begin
            // twelve oscillator periods per machine cycle
            mc_reg <= wrap_inc(mc_reg, OSC_MC);
            ale_ph_reg <= wrap_inc(ale_ph_reg, `RPMC_ALE_DIV);
        end
        // count two machine cycles of reset high
        if (!rst_in) begin
            rcnt_reg <= 5'h0;
            rst_q_reg <= 1'b0;
        end else if (state_reg == ST_PDOWN) begin
            // oscillator stopped: the held pin is trusted to outlast restart
            rst_q_reg <= 1'b1;
        end else if (osc_tick) begin
            if (rcnt_reg == RST_OSC - 5'h1) begin
                rst_q_reg <= 1'b1;
            end else begin
                rcnt_reg <= rcnt_reg + 5'h1;
            end
        end
    end
end
wire mc_end = osc_tick & (mc_reg == OSC_MC - 4'h1);
wire ale_slot = osc_tick & (ale_ph_reg == 4'h0);
// fetch drops count down at the end of each fetch pulse window
wire fetch_end = osc_tick & (ale_ph_reg == `RPMC_ALE_DIV - 4'h1);
wire ext_code = ~ea_hold_reg;

// ------------------------------------------------------------
// control register and code select latch
// ------------------------------------------------------------
wire ctrl_wr = wr_pend_reg & (wa_reg == `RPMC_CTRL_OFS);
wire irq0_hit = ctrl_reg[`RPMC_CTRL_IRQ0_EN] & i0_low;
wire irq1_hit = ctrl_reg[`RPMC_CTRL_IRQ1_EN] & i1_low;
wire irq0_pd = irq0_hit & ctrl_reg[`RPMC_CTRL_IRQ0_LVL];
wire irq1_pd = irq1_hit & ctrl_reg[`RPMC_CTRL_IRQ1_LVL];
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        ctrl_reg <= `RPMC_CTRL_RST;
        p2_reg <= 8'hff;
        ext_reg <= 3'h0;
        ext_go_reg <= 1'b0;
        ea_lat_reg <= 1'b0;
    end else begin
        if (rst_q_reg) begin
            ctrl_reg <= `RPMC_CTRL_RST;
            p2_reg <= 8'hff;
            ext_go_reg <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg <= hwdata[7:0];
            end else if (state_reg != ST_RUN) begin
                ctrl_reg[`RPMC_CTRL_IDLE] <= 1'b0;
                ctrl_reg[`RPMC_CTRL_PDOWN] <= 1'b0;
            end
            if (wr_pend_reg & (wa_reg == `RPMC_P2_OFS)) begin
                p2_reg <= hwdata[7:0];
            end
            // request stays until its slot begins, set wins over clear
            if (wr_pend_reg & (wa_reg == `RPMC_EXT_OFS)) begin
                ext_reg <= hwdata[2:0];
                ext_go_reg <= hwdata[`RPMC_EXT_DATA];
            end else if (mc_end & (state_reg == ST_RUN)) begin
                ext_go_reg <= 1'b0;
            end
        end
        // lock set: strap caught at reset, held until next reset
        if (rst_q_reg) begin
            ea_lat_reg <= ea_s[1];
        end
    end
end
always @* begin
    // low select means all fetches external
    ea_hold_reg = ctrl_reg[`RPMC_CTRL_LOCK] ? ea_lat_reg : ea_s[1];
end

// ------------------------------------------------------------
// mode machine
// ------------------------------------------------------------
reg ale_low_at_rst_reg;
reg pd_wake_reg;
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_RESET: begin
            // latch strobe held low across release enters emulation
            if (!rst_q_reg) begin
                state_next = ale_low_at_rst_reg ? ST_EMUL : ST_RUN;
            end
        end
        ST_RUN: begin
            // power-down takes effect once the request is done
            if (ctrl_reg[`RPMC_CTRL_PDOWN]) begin
                state_next = ST_PDOWN;
            end else if (ctrl_reg[`RPMC_CTRL_IDLE]) begin
                state_next = ST_IDLE;
            end
        end
        ST_IDLE: begin
            if (irq0_hit | irq1_hit) begin
                state_next = ST_RUN;
            end
        end
        ST_PDOWN: begin
            // level irq restarts oscillator, exit on release
            if (!(irq0_pd | irq1_pd) & pd_wake_reg) begin
                state_next = ST_RUN;
            end
        end
        ST_EMUL: state_next = ST_EMUL;
        default: state_next = ST_RESET;
    endcase
    // reset from any mode, emulation left only this way
    if (rst_q_reg) begin
        state_next = ST_RESET;
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        state_reg <= ST_RESET;
        ale_low_at_rst_reg <= 1'b0;
        pd_wake_reg <= 1'b0;
        idle_grace_reg <= 2'h0;
        skip_ale_reg <= 2'h0;
        skip_ps_reg <= 2'h0;
    end else begin
        state_reg <= state_next;
        if (state_reg == ST_RESET) begin
            // sampled while fetch strobe is held high in reset
            ale_low_at_rst_reg <= ~ale_s[1];
        end
        if (state_reg == ST_PDOWN) begin
            if (irq0_pd | irq1_pd) begin
                pd_wake_reg <= 1'b1;
            end else if (pd_wake_reg) begin
                pd_wake_reg <= 1'b0;
            end
        end
        // two machine cycles of run before reset takes over
        if ((state_reg == ST_IDLE) & rst_in) begin
            idle_grace_reg <= `RPMC_IDLE_GRACE_MC;
        end else if (mc_end & (idle_grace_reg != 2'h0)) begin
            idle_grace_reg <= idle_grace_reg - 2'h1;
        end
        // arm drops for one data access slot
        if (mc_end & ext_go_reg & (state_reg == ST_RUN)) begin
            skip_ale_reg <= 2'h1;
            skip_ps_reg <= 2'h2;
        end else begin
            if (ale_slot & (skip_ale_reg != 2'h0)) begin
                skip_ale_reg <= skip_ale_reg - 2'h1;
            end
            if (fetch_end & (skip_ps_reg != 2'h0)) begin
                skip_ps_reg <= skip_ps_reg - 2'h1;
            end
        end
    end
end

// ------------------------------------------------------------
// pin and core outputs
// ------------------------------------------------------------
wire running = (state_reg == ST_RUN);
wire ale_pulse = (ale_ph_reg == 4'h0);
wire data_acc = skip_ps_reg != 2'h0;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        ale_out <= 1'b1;
        ale_oe <= 1'b0;
        code_fetch_strobe <= 1'b1;
        code_fetch_oe <= 1'b0;
        port0_oe <= 1'b0;
        port2_addr_sel <= 1'b0;
        port2_out <= 8'hff;
        data_wr_strobe <= 1'b1;
        data_rd_strobe <= 1'b1;
        osc_run <= 1'b1;
        cpu_run <= 1'b0;
        ram_wr_block <= 1'b1;
        sfr_reset <= 1'b1;
        counter_array_en <= 1'b0;
        resume_after_pd <= 1'b0;
    end else begin
        // oscillator off in power-down until irq low
        osc_run <= (state_next != ST_PDOWN) | irq0_pd | irq1_pd;
        // execution stops in idle, state is simply not touched
        cpu_run <= (state_next == ST_RUN) | (idle_grace_reg != 2'h0);
        // ram writes blocked in the grace window, ports are not
        ram_wr_block <= (idle_grace_reg != 2'h0) | rst_q_reg;
        sfr_reset <= rst_q_reg;
        counter_array_en <= running |
            ((state_reg == ST_IDLE) & ctrl_reg[`RPMC_CTRL_CA_RUN]);
        // resume point is the instruction after power-down
        resume_after_pd <= pd_wake_reg & ~(irq0_pd | irq1_pd);
        // bits six and seven of port three are the data strobes
        data_wr_strobe <= ~(running & data_acc & ext_reg[`RPMC_EXT_WR]);
        data_rd_strobe <= ~(running & data_acc & ~ext_reg[`RPMC_EXT_WR]);
        ale_out <= 1'b1;
        ale_oe <= 1'b1;
        code_fetch_strobe <= 1'b1;
        code_fetch_oe <= 1'b1;
        port0_oe <= ~ext_code;
        port2_addr_sel <= 1'b0;
        port2_out <= p2_reg;
        case (state_reg)
            ST_RUN: begin
                // continuous strobe with one drop per access
                ale_out <= ale_pulse & (skip_ale_reg == 2'h0);
                // two fetch pulses per cycle, two dropped
                code_fetch_strobe <= ~(ext_code & ale_ph_reg[2] &
                    ~data_acc);
                port0_oe <= ext_code | data_acc;
                // 8-bit indirect access shows the latch contents
                port2_addr_sel <= data_acc ? ~ext_reg[`RPMC_EXT_IND8] :
                    ext_code;
            end
            // idle: strobes high, port two carries address if external
            ST_IDLE: port2_addr_sel <= ext_code;
            ST_PDOWN: begin
                // power-down: strobes low, port two keeps data
                ale_out <= 1'b0;
                code_fetch_strobe <= 1'b0;
            end
            ST_EMUL: begin
                // released: port zero floats, weak pull-ups only
                ale_oe <= 1'b0;
                code_fetch_oe <= 1'b0;
                port0_oe <= 1'b0;
                port2_out <= 8'hff;
            end
            default: begin
                // in reset the strobe pin is released so it can be sampled
                ale_oe <= 1'b0;
                port0_oe <= 1'b0;
                port2_out <= 8'hff;
            end
        endcase
    end
end

endmodule

/* rpmc_top_chk.sv */
// port assertions for the reset and power mode controller
`timescale 1ns/1ps
module rpmc_top_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic ext_code_select,
    input wire logic ale_out,
    input wire logic code_fetch_strobe,
    input wire logic port0_oe,
    input wire logic port2_addr_sel,
    input wire logic osc_run,
    input wire logic cpu_run,
    input wire logic ram_wr_block,
    input wire logic sfr_reset,
    input wire logic resume_after_pd
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    // a latch strobe period is twelve core clocks, so eight is safe
    sequence s_ale_quiet;
        (!$rose(ale_out)) [*8];
    endsequence
    // one cycle of slack after the oscillator stops
    sequence s_pd_settled;
        !osc_run && !$past(osc_run);
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    ale_spacing_a: assert property (
        $rose(ale_out) && cpu_run |=> s_ale_quiet)
        else $error("latch strobe pulses too close");
    pd_strobes_low_a: assert property (
        s_pd_settled |-> !ale_out && !code_fetch_strobe)
        else $error("strobes not low in power-down");
    pd_ports_a: assert property (
        s_pd_settled ##0 !ext_code_select |-> !port0_oe && !port2_addr_sel)
        else $error("port drive wrong in power-down");
    pd_halt_a: assert property (
        !osc_run |-> !cpu_run)
        else $error("core runs with oscillator stopped");
    reset_qual_a: assert property (
        $rose(sfr_reset) && $past(osc_run) |->
            $past(reset_pin, 8) && $past(reset_pin, 16))
        else $error("reset taken on a short pin pulse");
    reset_ram_a: assert property (
        sfr_reset |-> ram_wr_block)
        else $error("ram writable during reset");
    resume_pulse_a: assert property (
        resume_after_pd |-> osc_run ##1 !resume_after_pd)
        else $error("resume pulse malformed");
    wake_hold_a: assert property (
        $rose(osc_run) |-> (!cpu_run) [*2])
        else $error("core resumed before pin returned high");
endmodule

/* rpmc_far_model.sv */
// far-side model: reset source, interrupt lines, emulator strap
`timescale 1ns/1ps
module rpmc_far_model #(
    parameter int RST_HOLD = 64
) (
    input wire logic core_clk,
    input wire logic req_reset,
    input wire logic req_glitch,
    input wire logic req_irq0,
    input wire logic req_irq1,
    input wire logic req_emul,
    input wire logic ale_out,
    input wire logic ale_oe,
    input wire logic code_fetch_strobe,
    input wire logic code_fetch_oe,
    output logic reset_pin,
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic ale_pin_in
);
    logic [7:0] hold_cnt = 8'h00;
    logic emul_low = 1'b0;
    wire fetch_level = code_fetch_oe ? code_fetch_strobe : 1'b1;
    always @(posedge core_clk) begin
        if (req_reset) begin
            hold_cnt <= 8'(RST_HOLD);
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
        end
    end
    // glitch is deliberately shorter than two machine cycles
    assign reset_pin = req_reset || (hold_cnt != 8'h00) || req_glitch;
    // strap pulled low only in reset with fetch high, held until the request drops
    always @(posedge core_clk) begin
        if (!req_emul) begin
            emul_low <= 1'b0;
        end else if (reset_pin && fetch_level) begin
            emul_low <= 1'b1;
        end
    end
    // undriven strobe pin sits at its pull-up unless the emulator strap holds it low
    assign ale_pin_in = ale_oe ? ale_out : !emul_low;
    // level requests, lines pulled up when quiet
    assign ext_irq_zero = !req_irq0;
    assign ext_irq_one = !req_irq1;
endmodule

/* rpmc_top_tb_top.sv */
// self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
`include "rpmc_map.vh"
module rpmc_top_tb_top;
    localparam logic [31:0] A_CTRL = 32'(`RPMC_CTRL_OFS);
    localparam logic [31:0] A_STAT = 32'(`RPMC_STAT_OFS);
    localparam logic [31:0] A_EXT = 32'(`RPMC_EXT_OFS);
    localparam logic [31:0] A_P2 = 32'(`RPMC_P2_OFS);
    localparam logic [31:0] IDL = 32'h1 << `RPMC_CTRL_IDLE;
    localparam logic [31:0] PD = 32'h1 << `RPMC_CTRL_PDOWN;
    localparam logic [31:0] CA = 32'h1 << `RPMC_CTRL_CA_RUN;
    localparam logic [31:0] E0 = 32'h1 << `RPMC_CTRL_IRQ0_EN;
    localparam logic [31:0] E1 = 32'h1 << `RPMC_CTRL_IRQ1_EN;
    localparam logic [31:0] L0 = 32'h1 << `RPMC_CTRL_IRQ0_LVL;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic haddr_sel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ext_code_select = 1'b0;
    logic req_reset = 1'b0;
    logic req_glitch = 1'b0;
    logic req_irq0 = 1'b0;
    logic req_irq1 = 1'b0;
    logic req_emul = 1'b0;
    wire [31:0] hrdata;
    wire [7:0] port2_out;
    wire hreadyout, hresp, reset_pin, ext_irq_zero, ext_irq_one, ale_pin_in;
    wire ale_out, ale_oe, code_fetch_strobe, code_fetch_oe, port0_oe;
    wire port2_addr_sel, data_wr_strobe, data_rd_strobe, osc_run, cpu_run;
    wire ram_wr_block, sfr_reset, counter_array_en, resume_after_pd;
    int n_mismatch = 0;
    int check_count = 0;
    int w_ale, w_cfs;
    logic w_rd, w_wr, w_sel;
    logic [7:0] w_p2;
    rpmc_top rpmc_top_i (.hready(hreadyout), .*);
    rpmc_far_model rpmc_far_model_i (.*);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_b(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_w(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic bus_xfer(input logic [31:0] a, input logic wr,
                            input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        haddr_sel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        haddr_sel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(a, 1'b0, 32'h0, q);
        chk_w(nm, e, q);
    endtask
    task automatic wait_mode(input logic [31:0] e);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 100 && (s & 32'h1f) !== e; i++) begin
            bus_xfer(A_STAT, 1'b0, 32'h0, s);
        end
        chk_w("mode", e, s & 32'h1f);
    endtask
    // counts strobe edges over a window; captures port two at access
    task automatic watch(input int n);
        logic pa, pf;
        pa = ale_out;
        pf = code_fetch_strobe;
        w_ale = 0;
        w_cfs = 0;
        w_rd = 1'b0;
        w_wr = 1'b0;
        w_sel = 1'b1;
        w_p2 = 8'h00;
        repeat (n) begin
            @(posedge core_clk);
            if (ale_out === 1'b1 && pa === 1'b0) w_ale++;
            if (code_fetch_strobe === 1'b0 && pf === 1'b1) w_cfs++;
            if (data_rd_strobe === 1'b0 || data_wr_strobe === 1'b0) begin
                w_rd = w_rd | (data_rd_strobe === 1'b0);
                w_wr = w_wr | (data_wr_strobe === 1'b0);
                w_p2 = port2_out;
                w_sel = port2_addr_sel;
            end
            pa = ale_out;
            pf = code_fetch_strobe;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_boot;
        wait_mode(32'h2);
        rd_chk("ctrl", A_CTRL, 32'h0);
        bus_wr(32'h10, 32'hffff_ffff);
        rd_chk("hole", 32'h10, 32'h0);
        bus_wr(A_CTRL, CA);
        req_glitch <= 1'b1;
        tick(20);
        req_glitch <= 1'b0;
        tick(10);
        chk_b("sfr_reset", 1'b0, sfr_reset);
        rd_chk("ctrl", A_CTRL, CA);
    endtask
    // 120 core clocks are 60 oscillator ticks, five machine cycles
    task automatic t_rates;
        watch(120);
        chk_w("ale", 32'd10, w_ale);
        chk_w("fetch", 32'd10, w_cfs);
        ext_code_select <= 1'b1;
        tick(8);
        watch(120);
        chk_w("fetch int", 32'd0, w_cfs);
        bus_wr(A_CTRL, 32'h1 << `RPMC_CTRL_LOCK);
        rd_chk("lock", A_STAT, 32'h2);
        ext_code_select <= 1'b0;
        tick(8);
    endtask
    task automatic t_xdata;
        bus_wr(A_P2, 32'h5a);
        bus_wr(A_EXT, 32'h7);
        watch(120);
        chk_w("ale", 32'd9, w_ale);
        chk_w("fetch", 32'd8, w_cfs);
        chk_b("wr", 1'b1, w_wr);
        chk_w("p2", 32'h5a, {24'h0, w_p2});
        chk_b("p2 sel", 1'b0, w_sel);
        bus_wr(A_EXT, 32'h3);
        watch(120);
        chk_b("rd", 1'b1, w_rd);
        chk_w("ale", 32'd9, w_ale);
    endtask
    task automatic t_idle;
        bus_wr(A_CTRL, IDL | E1);
        tick(30);
        chk_b("cpu_run", 1'b0, cpu_run);
        chk_b("osc_run", 1'b1, osc_run);
        chk_b("ale", 1'b1, ale_out);
        chk_b("fetch", 1'b1, code_fetch_strobe);
        chk_b("p0 oe", 1'b0, port0_oe);
        chk_b("p2 sel", 1'b1, port2_addr_sel);
        chk_b("ca", 1'b0, counter_array_en);
        rd_chk("p2", A_P2, 32'h5a);
        req_irq1 <= 1'b1;
        wait_mode(32'h2);
        req_irq1 <= 1'b0;
        bus_wr(A_CTRL, IDL | CA);
        tick(30);
        chk_b("ca", 1'b1, counter_array_en);
        req_reset <= 1'b1;
        for (int i = 0; i < 200 && sfr_reset !== 1'b1; i++) tick(1);
        chk_b("ram blk", 1'b1, ram_wr_block);
        req_reset <= 1'b0;
        wait_mode(32'h2);
        rd_chk("ctrl", A_CTRL, 32'h0);
        chk_b("p2 ff", 1'b1, &port2_out);
    endtask
    task automatic t_pdown;
        bus_wr(A_P2, 32'h5a);
        bus_wr(A_CTRL, PD | E0 | L0);
        tick(30);
        chk_b("osc_run", 1'b0, osc_run);
        chk_b("ale", 1'b0, ale_out);
        chk_b("fetch", 1'b0, code_fetch_strobe);
        chk_b("p0 oe", 1'b0, port0_oe);
        req_irq0 <= 1'b1;
        for (int i = 0; i < 200 && osc_run !== 1'b1; i++) tick(1);
        tick(4);
        chk_b("osc_run", 1'b1, osc_run);
        chk_b("cpu_run", 1'b0, cpu_run);
        req_irq0 <= 1'b0;
        for (int i = 0; i < 200 && resume_after_pd !== 1'b1; i++) tick(1);
        chk_b("resume", 1'b1, resume_after_pd);
        wait_mode(32'h2);
        rd_chk("p2", A_P2, 32'h5a);
    endtask
    task automatic t_emul;
        req_emul <= 1'b1;
        req_reset <= 1'b1;
        tick(80);
        req_reset <= 1'b0;
        wait_mode(32'h10);
        chk_b("p0 oe", 1'b0, port0_oe);
        chk_b("ale oe", 1'b0, ale_oe);
        chk_b("fetch oe", 1'b0, code_fetch_oe);
        chk_b("osc_run", 1'b1, osc_run);
        req_emul <= 1'b0;
        req_reset <= 1'b1;
        tick(80);
        req_reset <= 1'b0;
        wait_mode(32'h2);
        chk_b("ale oe", 1'b1, ale_oe);
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_boot;
        t_rates;
        t_xdata;
        t_idle;
        t_pdown;
        t_emul;
        tally_and_finish;
    end
endmodule
bind rpmc_top rpmc_top_chk rpmc_top_chk_i (.*);
